// ==== rtl/crccu_map.vh ====
// register map and constants of the crc calculation unit
// ----------------------------------------------------------------------------
// How it works
// RQ1: writing the data register feeds the calculator; reading returns result.
// RQ2: first calculation starts from init value, later ones from last result.
// RQ3: each calculation finishes within four bus clock cycles.
// RQ4: every calculator reset copies the init register into the data register.
// RQ5: control bit 0 written 1 resets calculator, self-clears; 0 does nothing.
// RQ6: scratch byte register holds one byte and survives calculator reset.
// RQ7: input reversal field: none, per byte, per half-word or whole word.
// RQ8: output reversal bit mirrors the whole 32-bit result before reading.
// RQ9: reversal mirrors bits inside 8-, 16- or 32-bit groups.
// RQ10: polynomial size field: 32, 16, 8 or 7 bits.
// RQ11: crc is modulo-2 remainder by generator, default 0x4C11DB7.
// RQ12: final exclusive-or is all zeros.
// RQ13: default start value is all ones.
// RQ14: software uses 8/16/32-bit data accesses, 32-bit elsewhere.
// RQ15: polynomial register is writable and used by later calculations.
// RQ16: byte or half-word data writes fold only the written bits; here an input reversal wider than the write folds bits of unwritten lanes.
// RQ17: data register access during a calculation stalls until it ends; here only reads wait, writes stall only on a full fifo.
// ----------------------------------------------------------------------------
`ifndef CRCCU_MAP_VH
`define CRCCU_MAP_VH
`define CRCCU_OFS_DATA   12'h000
`define CRCCU_OFS_SCR    12'h004
`define CRCCU_OFS_CTRL   12'h008
`define CRCCU_OFS_INIT   12'h010
`define CRCCU_OFS_GENERATOR_COEFF   12'h014
`define CRCCU_RST_DATA   32'hFFFFFFFF
`define CRCCU_RST_INIT   32'hFFFFFFFF
`define CRCCU_RST_GENERATOR_COEFF   32'h04C11DB7
`define CRCCU_RST_ZERO   32'h00000000
`define CRCCU_XOR_OUT    32'h00000000
`define CRCCU_CTRL_RST   0
`define CRCCU_CTRL_OREV  7
`define CRCCU_REV_HI     6
`define CRCCU_REV_LO     5
`define CRCCU_SIZE_HI    4
`define CRCCU_SIZE_LO    3
`define CRCCU_REV_NONE   2'h0
`define CRCCU_REV_BYTE   2'h1
`define CRCCU_REV_HALF   2'h2
`define CRCCU_SZ_32      2'h0
`define CRCCU_SZ_16      2'h1
`define CRCCU_SZ_8       2'h2
`define CRCCU_CALC_CYC   3'h4
`define CRCCU_BITS_STEP  4'h8
`define CRCCU_FIFO_DW    34
`define CRCCU_FIFO_DEP   16
`define CRCCU_FIFO_AW    4
`endif

// ==== rtl/crccu_top.v ====
// crc calculation unit with apb slave and a data fifo
//
// Design decision made here: register access over APB.
`include "crccu_map.vh"

// ----------------------------------------------------------------------------
// fifo
// ----------------------------------------------------------------------------
module crccu_fifo #(
  parameter DW = 34,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input  wire          clk,      // bus clock
  input  wire          rst_n,    // async reset, low
  input  wire [DW-1:0] in_data,  // write data
  input  wire          in_valid, // write request
  output wire          in_ready, // not full
  output wire [DW-1:0] out_data, // head word
  output wire          out_valid,// not empty
  input  wire          out_ready // head taken
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW:0]   wp_r;
  reg [AW:0]   rp_r;
  wire         full  = (wp_r[AW] != rp_r[AW]) &&
                       (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire         empty = (wp_r == rp_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rp_r[AW-1:0]];
  always @(posedge clk) begin
    if (in_valid && !full)
      mem[wp_r[AW-1:0]] <= in_data;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= {(AW+1){1'b0}};
      rp_r <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full)
        wp_r <= wp_r + 1'b1;
      if (out_ready && !empty)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule

// ----------------------------------------------------------------------------
// top
// ----------------------------------------------------------------------------
module crccu_top (
  input  wire        clk,     // 50 MHz bus clock
  input  wire        rst_n,   // async reset, low
  input  wire        psel,    // apb select
  input  wire        penable, // apb enable
  input  wire        pwrite,  // apb direction
  input  wire [11:0] paddr,   // apb byte address
  input  wire [31:0] pwdata,  // apb write data
  input  wire [3:0]  pstrb,   // apb byte strobes
  output reg  [31:0] prdata,  // apb read data
  output wire        pready,  // apb ready
  output wire        pslverr  // apb error
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CALC = 1'b1;

  reg  [31:0] data_result_value_r;
  reg  [7:0]  scratch_byte_value_r;
  reg         output_reverse_sel_r;
  reg  [1:0]  input_reverse_sel_r;
  reg  [1:0]  generator_width_sel_r;
  reg  [31:0] init_value_r;
  reg  [31:0] generator_coeff_r;
  reg         st_r;
  reg  [2:0]  cyc_r;
  reg  [31:0] sh_r;
  reg  [1:0]  len_r;
  reg         rd_ok_r;
  wire [31:0] crc_nxt;
  wire [31:0] in_rev;
  wire [31:0] res_rev;
  // running value and input word after each of the eight division steps
  wire [31:0] stg_crc [0:8];
  wire [31:0] stg_ins [0:8];

  wire setup   = psel && !penable;
  wire access  = psel && penable;
  wire a_data  = (paddr == `CRCCU_OFS_DATA);
  wire a_scr   = (paddr == `CRCCU_OFS_SCR);
  wire a_ctrl  = (paddr == `CRCCU_OFS_CTRL);
  wire a_init  = (paddr == `CRCCU_OFS_INIT);
  wire a_generator_coeff  = (paddr == `CRCCU_OFS_GENERATOR_COEFF);
  wire mapped  = a_data | a_scr | a_ctrl | a_init | a_generator_coeff;

  // data writes go through the fifo; reads wait for it to drain
  wire [`CRCCU_FIFO_DW-1:0] f_in;
  wire [`CRCCU_FIFO_DW-1:0] f_out;
  wire f_in_ready;
  wire f_out_valid;
  wire f_take;
  wire busy = (st_r == ST_CALC) || f_out_valid;
  wire dwr  = access && pwrite && a_data;
  // write stalls only on a full fifo, read of result waits for all work
  // and for the cycle that loads the result into prdata
  assign pready = !access ? 1'b1 :
                  (!a_data ? 1'b1 :
                   (pwrite ? f_in_ready :
                    (!busy && rd_ok_r)));                  // see RQ17
  assign pslverr = access && !mapped;
  wire wr_done = access && pwrite && pready;
  // a read that has not yet been answered
  wire rd_pend = psel && !pwrite && !(access && pready);

  // size code: 0 byte, 1 half, 2 word; chooses bits folded
  wire [1:0] wlen = (pstrb == 4'h1) ? 2'h0 :
                    (pstrb == 4'h3) ? 2'h1 : 2'h2;         // see RQ16
  assign f_in = {wlen, pwdata};

  crccu_fifo #(
    .DW    (`CRCCU_FIFO_DW),
    .DEPTH (`CRCCU_FIFO_DEP),
    .AW    (`CRCCU_FIFO_AW)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (f_in),
    .in_valid  (dwr && f_in_ready),
    .in_ready  (f_in_ready),
    .out_data  (f_out),
    .out_valid (f_out_valid),
    .out_ready (f_take)
  );
  assign f_take = (st_r == ST_IDLE) && f_out_valid;

  // ----------------------------------------------------------------------------
  // bit reversal, one slice per bit position
  // ----------------------------------------------------------------------------
  genvar gb;
  generate
    for (gb = 0; gb < 32; gb = gb + 1) begin : g_rev
      // mirror partners of this bit inside a byte, a half-word, the word
      wire rb_byte = f_out[(gb & 24) + 7 - (gb & 7)];
      wire rb_half = f_out[(gb & 16) + 15 - (gb & 15)];
      wire rb_word = f_out[31 - gb];
      reg  rb_sel;
      always @* begin
        case (input_reverse_sel_r)
          `CRCCU_REV_NONE: rb_sel = f_out[gb];
          `CRCCU_REV_BYTE: rb_sel = rb_byte;
          `CRCCU_REV_HALF: rb_sel = rb_half;
          default:         rb_sel = rb_word;
        endcase                                            // see RQ7 RQ9
      end
      assign in_rev[gb] = rb_sel;
      // output side only knows whole-word reversal
      assign res_rev[gb] = output_reverse_sel_r ?
                           data_result_value_r[31 - gb] :
                           data_result_value_r[gb];        // see RQ8
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // division steps: eight per cycle, msb first, width aligned
  // ----------------------------------------------------------------------------
  // a deeper chain would shorten words but lengthen the critical path
  assign stg_crc[0] = data_result_value_r;
  assign stg_ins[0] = sh_r;
  genvar gs;
  generate
    for (gs = 0; gs < 8; gs = gs + 1) begin : g_step
      reg        fb;
      reg [31:0] nx;
      always @* begin
        case (generator_width_sel_r)
          `CRCCU_SZ_32: fb = stg_crc[gs][31] ^ stg_ins[gs][31];
          `CRCCU_SZ_16: fb = stg_crc[gs][15] ^ stg_ins[gs][31];
          `CRCCU_SZ_8:  fb = stg_crc[gs][7] ^ stg_ins[gs][31];
          default:      fb = stg_crc[gs][6] ^ stg_ins[gs][31];
        endcase                                            // see RQ10
        nx = {stg_crc[gs][30:0], 1'b0};
        if (fb)
          nx = nx ^ generator_coeff_r;                     // see RQ11 RQ15
        // bits above the chosen width never feed back
        case (generator_width_sel_r)
          `CRCCU_SZ_32: nx = nx;
          `CRCCU_SZ_16: nx = nx & 32'h0000FFFF;
          `CRCCU_SZ_8:  nx = nx & 32'h000000FF;
          default:      nx = nx & 32'h0000007F;
        endcase
      end
      assign stg_crc[gs+1] = nx;
      assign stg_ins[gs+1] = {stg_ins[gs][30:0], 1'b0};
    end
  endgenerate
  assign crc_nxt = stg_crc[8];

  // ----------------------------------------------------------------------------
  // calculator and registers
  // ----------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_result_value_r   <= `CRCCU_RST_DATA;            // see RQ13
      scratch_byte_value_r  <= 8'h00;
      output_reverse_sel_r  <= 1'b0;
      input_reverse_sel_r   <= 2'h0;
      generator_width_sel_r <= 2'h0;
      init_value_r          <= `CRCCU_RST_INIT;
      generator_coeff_r     <= `CRCCU_RST_GENERATOR_COEFF;
      st_r                  <= ST_IDLE;
      cyc_r                 <= 3'h0;
      sh_r                  <= 32'h00000000;
      len_r                 <= 2'h0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (f_out_valid) begin
            st_r  <= ST_CALC;
            len_r <= f_out[33:32];
            cyc_r <= 3'h1;
            // narrow data aligned to the top so only the low 8 or 16 bits of in_rev fold
            case (f_out[33:32])
              2'h0:    sh_r <= {in_rev[7:0], 24'h000000};
              2'h1:    sh_r <= {in_rev[15:0], 16'h0000};
              default: sh_r <= in_rev;
            endcase                                        // see RQ1 RQ16
          end
        end
        ST_CALC: begin
          // running result is the start value of each step
          data_result_value_r <= crc_nxt ^ `CRCCU_XOR_OUT; // see RQ2 RQ12
          sh_r  <= {sh_r[23:0], 8'h00};
          cyc_r <= cyc_r + 3'h1;
          if ((len_r == 2'h0) ||
              (len_r == 2'h1 && cyc_r == 3'h2) ||
              (cyc_r == `CRCCU_CALC_CYC))
            st_r <= ST_IDLE;                               // see RQ3
        end
        default: st_r <= ST_IDLE;
      endcase
      if (wr_done && a_scr)
        scratch_byte_value_r <= pwdata[7:0];               // see RQ6
      if (wr_done && a_ctrl) begin
        output_reverse_sel_r  <= pwdata[`CRCCU_CTRL_OREV];
        input_reverse_sel_r   <= pwdata[`CRCCU_REV_HI:`CRCCU_REV_LO];
        generator_width_sel_r <= pwdata[`CRCCU_SIZE_HI:`CRCCU_SIZE_LO];
        // reset bit is never stored: it acts once and reads back 0
        if (pwdata[`CRCCU_CTRL_RST])
          data_result_value_r <= init_value_r;             // see RQ4 RQ5
      end
      if (wr_done && a_init)
        init_value_r <= pwdata;
      if (wr_done && a_generator_coeff)
        generator_coeff_r <= pwdata;                       // see RQ15
    end
  end

  // ----------------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= `CRCCU_RST_ZERO;
      rd_ok_r <= 1'b0;
    end else begin
      // result is loaded one cycle ahead of pready, so the master
      // samples the new value and never the previous one
      rd_ok_r <= rd_pend && a_data && !busy;               // see RQ17
      if (setup && !pwrite && !a_data) begin
      case (paddr)
        `CRCCU_OFS_SCR:  prdata <= {24'h000000, scratch_byte_value_r};
        `CRCCU_OFS_CTRL: prdata <= {24'h000000, output_reverse_sel_r,
                                    input_reverse_sel_r,
                                    generator_width_sel_r, 3'h0};
        `CRCCU_OFS_INIT: prdata <= init_value_r;
        `CRCCU_OFS_GENERATOR_COEFF: prdata <= generator_coeff_r;
        default:         prdata <= `CRCCU_RST_ZERO;
      endcase
      end else if (rd_pend && a_data && !busy)
        prdata <= res_rev;                                 // see RQ1 RQ8
    end
  end
endmodule

// ==== tb/crccu_asserts.sv ====
// concurrent checks on the apb port of the crc unit
module crccu_asserts (
  input logic        clk,     // bus clock
  input logic        rst_n,   // async reset, low
  input logic        psel,    // select
  input logic        penable, // enable
  input logic        pwrite,  // direction
  input logic [11:0] paddr,   // byte address
  input logic [31:0] pwdata,  // write data
  input logic [3:0]  pstrb,   // strobes
  input logic [31:0] prdata,  // read data
  input logic        pready,  // ready
  input logic        pslverr  // error
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire rd  = acc && !pwrite;
  wire hit = paddr inside {12'h000, 12'h004, 12'h008, 12'h010, 12'h014};
  sequence s_data_stall;
    acc && paddr == 12'h000 && !pready;
  endsequence
  sequence s_ready_soon;
    ##[1:200] pready;
  endsequence
  a_err_unmapped:
    assert property (acc && !hit |-> pslverr && pready)
    else $error("unmapped access not refused");
  a_err_mapped:
    assert property (acc && hit |-> !pslverr)
    else $error("error on a mapped register");
  a_reg_nowait:
    assert property (acc && hit && paddr != 12'h000 |-> pready)
    else $error("wait state on a plain register");
  a_ctrl_selfclr:
    assert property (rd && paddr == 12'h008 |-> prdata[0] == 1'h0)
    else $error("reset bit reads back set");
  a_scr_byte:
    assert property (rd && paddr == 12'h004 |-> prdata[31:8] == 24'h0)
    else $error("scratch holds more than a byte");
  a_unmap_zero:
    assert property (rd && !hit |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_data_stall:
    assert property (s_data_stall |-> s_ready_soon)
    else $error("data access stalled too long");
  a_reset_idle:
    assert property ($rose(rst_n) |-> pready && !pslverr && !prdata)
    else $error("port not idle after reset");
endmodule
bind crccu_top crccu_asserts crccu_asserts_i (.clk, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);

// ==== tb/test_crc_calculation_unit.sv ====
// self-checking bench for the crc calculation unit
module test_crc_calculation_unit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] P = 32'h04C11DB7;
  logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
  logic        pwrite = 1'h0, tick = 1'h0, pready, pslverr, s_rdy, s_err, qe;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, s_rd, q, e, w, ini = 32'hFFFFFFFF;
  logic [3:0]  pstrb = 4'h0;
  int          n_fail = 0, checks_done = 0;
  crccu_top crccu_top_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr);
  initial begin
    forever #10 clk = ~clk;
  end
  // edge samples, so the tasks never race the design's own updates
  always @(posedge clk) begin
    s_rdy <= pready & psel & penable;
    s_rd  <= prdata;
    s_err <= pslverr;
    tick  <= ~tick;
  end
  // ---------------------------------------------------------------
  // tasks and reference model
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w_, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
    psel    <= 1'h1;
    pwrite  <= w_;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(tick);
    penable <= 1'h1;
    do @(tick); while (s_rdy !== 1'h1);
    psel    <= 1'h0;
    penable <= 1'h0;
    q  = s_rd;
    qe = s_err;
    @(tick);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'h1, a, d, 4'hF);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    xfer(1'h0, a, 32'h0, 4'h0);
    chk(q, x);
  endtask
  function automatic logic [31:0] rev(input logic [31:0] d, input int m);
    int g;
    g = (m == 1) ? 8 : (m == 2) ? 16 : 32;
    for (int i = 0; i < 32; i++)
      rev[i] = (m == 0) ? d[i] : d[i / g * g + g - 1 - i % g];
  endfunction
  function automatic logic [31:0] fold(input logic [31:0] c, d,
                                       input int nb, n, input logic [31:0] p);
    logic [31:0] mk;
    logic        fb;
    mk = (n == 32) ? 32'hFFFFFFFF : (32'h1 << n) - 32'h1;
    c = c & mk;
    for (int i = nb - 1; i >= 0; i--) begin
      fb = c[n - 1] ^ d[i];
      c  = (c << 1) & mk;
      if (fb) c = c ^ (p & mk);
    end
    return c;
  endfunction
  task automatic wrap_up;
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up;
  end
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(tick);
    rdc(12'h000, 32'hFFFFFFFF);
    rdc(12'h004, 32'h0);
    rdc(12'h008, 32'h0);
    rdc(12'h010, 32'hFFFFFFFF);
    rdc(12'h014, P);
    rdc(12'h00C, 32'h0);
    chk({31'h0, qe}, 32'h1);
    e = fold(32'hFFFFFFFF, 32'h12345678, 32, 32, P);
    wr(12'h000, 32'h12345678);
    wr(12'h008, 32'h0);
    wr(12'h000, 32'hCAFE0001);
    rdc(12'h000, fold(e, 32'hCAFE0001, 32, 32, P));
    wr(12'h004, 32'hFFFFFFAB);
    ini = 32'h11223344;
    wr(12'h010, ini);
    wr(12'h008, 32'h1);
    rdc(12'h000, ini);
    rdc(12'h004, 32'hAB);
    rdc(12'h008, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(12'h008, {24'h0, m[0], m[1:0], 5'h1});
      e = fold(ini, rev(32'h12345678, m), 32, 32, P);
      wr(12'h000, 32'h12345678);
      rdc(12'h000, m[0] ? rev(e, 3) : e);
    end
    wr(12'h008, 32'h1);
    e = ini;
    w = 32'h0;
    // enough back-to-back words to overrun the calculator and fill the fifo
    for (int i = 0; i < 48; i++) begin
      w = w + 32'h01000193;
      wr(12'h000, w);
      e = fold(e, w, 32, 32, P);
    end
    rdc(12'h000, e);
    wr(12'h014, 32'h7);
    wr(12'h008, 32'h11);
    xfer(1'h1, 12'h000, 32'hFFFFFFA5, 4'h1);
    xfer(1'h1, 12'h000, 32'hABCD1234, 4'h3);
    rdc(12'h014, 32'h7);
    e = fold(fold(ini, 32'hA5, 8, 8, 32'h7), 32'h1234, 16, 8, 32'h7);
    rdc(12'h000, e);
    chk(q & 32'hFF, e);
    wrap_up;
  end
endmodule
